// [src/fvs_device.sv]
/*
 * flash device end: volatile status register one, command gating and
 * the serial shifter that carries opcodes, write data and status reads.
 * assumes the embedded operation engine, protected-range decode and
 * non-volatile storage sit on the user side; the link clock comes from the host.
 */
`include "fvs_params.svh"

module fvs_device
  import fvs_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_srst,
  fvs_link_if.device link,
  input wire logic [7:0] i_nv_status,
  input wire logic i_protect_volatility_select,
  input wire logic i_target_protected,
  input wire logic i_op_done,
  input wire logic i_op_fail,
  output logic o_program_start,
  output logic o_erase_start,
  output logic o_whole_erase_start,
  output logic o_erase_suspend,
  output logic o_program_suspend,
  output logic o_nv_bp_write,
  output logic [2:0] o_nv_bp_data,
  output logic [7:0] o_volatile_status_one
);

  // ********************************
  // command classification
  // ********************************
  function automatic logic is_read(input logic [7:0] op);
    return op == `FVS_OP_READ_STATUS_ONE || op == `FVS_OP_READ_ANY_REG;
  endfunction

  function automatic logic is_reg_write(input logic [7:0] op);
    return op == `FVS_OP_WRITE_REGS || op == `FVS_OP_WRITE_ANY_REG;
  endfunction

  function automatic logic is_clear(input logic [7:0] op);
    return op == `FVS_OP_CLEAR_STATUS_A || op == `FVS_OP_CLEAR_STATUS_B;
  endfunction

  // ********************************
  // link sampling
  // ********************************
  logic [2:0] pins;
  logic sclk_prev_q;
  logic [4:0] bit_cnt_q;
  logic [7:0] shift_q;
  logic [7:0] opcode_q;
  logic [7:0] out_q;
  logic miso_q;

  fvs_sync3 #(.WIDTH(3), .INIT(3'h2)) u_sync (
    .i_ref_clk(i_ref_clk),
    .i_srst(i_srst),
    .i_async({link.sclk, link.cs_n, link.mosi}),
    .o_sync(pins)
  );

  logic sclk_s;
  logic cs_n_s;
  logic mosi_s;
  logic rise;
  logic fall;
  logic byte_done;
  logic first_done;
  logic second_done;
  logic [7:0] rx_byte;

  assign sclk_s = pins[2];
  assign cs_n_s = pins[1];
  assign mosi_s = pins[0];
  assign rise = sclk_s & ~sclk_prev_q & ~cs_n_s;
  assign fall = ~sclk_s & sclk_prev_q & ~cs_n_s;
  assign rx_byte = {shift_q[6:0], mosi_s};
  assign byte_done = rise && bit_cnt_q[2:0] == `FVS_BYTE_LAST;
  assign first_done = rise && bit_cnt_q == `FVS_FIRST_BYTE_END;
  assign second_done = rise && bit_cnt_q == `FVS_SECOND_BYTE_END;

  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      sclk_prev_q <= 1'b0;
    end else begin
      sclk_prev_q <= sclk_s;
    end
  end

  // counter wraps from the second byte end back to the first bit of the second byte so long reads keep repeating
  always_ff @(posedge i_ref_clk) begin
    if (i_srst || cs_n_s) begin
      bit_cnt_q <= `FVS_BIT_CNT_RESET;
      shift_q <= 8'h00;
    end else if (rise) begin
      shift_q <= rx_byte;
      if (bit_cnt_q != `FVS_SECOND_BYTE_END) begin
        bit_cnt_q <= bit_cnt_q + 5'h01;
      end else begin
        bit_cnt_q <= `FVS_FIRST_BYTE_END + 5'h01;
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      opcode_q <= 8'h00;
    end else if (first_done) begin
      opcode_q <= rx_byte;
    end
  end

  // ********************************
  // status register state
  // ********************************
  logic busy_q;
  logic wel_q;
  logic p_err_q;
  logic e_err_q;
  logic [2:0] bp_q;
  logic mirror_q;
  fvs_op_e op_q;
  logic [7:0] status;
  logic [2:0] bp_active;
  logic cmd;
  logic soft_reset;
  logic may_write;
  logic op_end;
  logic set_p;
  logic set_e;
  logic clr_err;
  logic start_prog;
  logic start_erase;
  logic start_whole;
  logic reg_write;

  assign status = {mirror_q, p_err_q, e_err_q, bp_q, wel_q, busy_q};
  assign bp_active = i_protect_volatility_select ? bp_q :
                     i_nv_status[`FVS_BIT_BP_HI:`FVS_BIT_BP_LO];
  assign cmd = first_done;
  assign soft_reset = cmd && rx_byte == `FVS_OP_SOFT_RESET;
  assign may_write = !busy_q && wel_q;
  assign op_end = i_op_done && busy_q && op_q != FVS_OP_NONE;
  assign start_prog = cmd && may_write && rx_byte == `FVS_OP_PROGRAM;
  assign start_erase = cmd && may_write && rx_byte == `FVS_OP_SECTOR_ERASE;
  // a refused whole erase leaves every flag as it was
  assign start_whole = cmd && may_write && rx_byte == `FVS_OP_WHOLE_ERASE &&
                       bp_active == 3'h0;
  assign reg_write = second_done && is_reg_write(opcode_q) && may_write;
  assign set_p = (start_prog && i_target_protected) ||
                 (op_end && i_op_fail && op_q == FVS_OP_PROG);
  // whole erase failures report nothing here, protected sectors included
  assign set_e = (start_erase && i_target_protected) ||
                 (op_end && i_op_fail && op_q == FVS_OP_ERASE);
  assign clr_err = cmd && is_clear(rx_byte);

  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      mirror_q <= 1'b0;
    end else begin
      mirror_q <= i_nv_status[`FVS_BIT_STATUS_WRITE_DISABLE_MIRROR];
    end
  end

  // error flags: a hardware set in the clearing cycle wins
  always_ff @(posedge i_ref_clk) begin
    if (i_srst || soft_reset) begin
      p_err_q <= i_nv_status[`FVS_BIT_P_ERR];
      e_err_q <= i_nv_status[`FVS_BIT_E_ERR];
    end else begin
      p_err_q <= (p_err_q & ~clr_err) | set_p;
      e_err_q <= (e_err_q & ~clr_err) | set_e;
    end
  end

  // no branch takes register-write data, so writes never touch busy
  always_ff @(posedge i_ref_clk) begin
    if (i_srst || soft_reset) begin
      busy_q <= i_nv_status[`FVS_BIT_BUSY];
      op_q <= FVS_OP_NONE;
    end else if (set_p || set_e) begin
      busy_q <= 1'b1;
      op_q <= FVS_OP_NONE;
    end else if (start_prog) begin
      busy_q <= 1'b1;
      op_q <= FVS_OP_PROG;
    end else if (start_erase) begin
      busy_q <= 1'b1;
      op_q <= FVS_OP_ERASE;
    end else if (start_whole) begin
      busy_q <= 1'b1;
      op_q <= FVS_OP_WHOLE;
    end else if (op_end && !(i_op_fail && op_q == FVS_OP_WHOLE)) begin
      busy_q <= 1'b0;
      op_q <= FVS_OP_NONE;
    end else if (op_end) begin
      busy_q <= 1'b1;
      op_q <= FVS_OP_NONE;
    end else if (clr_err && (p_err_q || e_err_q || op_q == FVS_OP_NONE)) begin
      busy_q <= 1'b0;
    end
  end

  // every reset, soft reset included, loads the latch from bit 1 of i_nv_status
  always_ff @(posedge i_ref_clk) begin
    if (i_srst || soft_reset) begin
      wel_q <= i_nv_status[`FVS_BIT_WEL];
    end else if (op_end && !i_op_fail) begin
      wel_q <= 1'b0;
    end else if (reg_write) begin
      wel_q <= 1'b0;
    end else if (cmd && !busy_q && rx_byte == `FVS_OP_WRITE_ENABLE) begin
      wel_q <= 1'b1;
    end else if (cmd && !busy_q && rx_byte == `FVS_OP_WRITE_DISABLE) begin
      wel_q <= 1'b0;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_srst || soft_reset) begin
      bp_q <= i_nv_status[`FVS_BIT_BP_HI:`FVS_BIT_BP_LO];
    end else if (reg_write) begin
      bp_q <= rx_byte[`FVS_BIT_BP_HI:`FVS_BIT_BP_LO];
    end else if (!i_protect_volatility_select) begin
      bp_q <= i_nv_status[`FVS_BIT_BP_HI:`FVS_BIT_BP_LO];
    end
  end

  // ********************************
  // strobes to the embedded side
  // ********************************
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      o_program_start <= 1'b0;
      o_erase_start <= 1'b0;
      o_whole_erase_start <= 1'b0;
      o_erase_suspend <= 1'b0;
      o_program_suspend <= 1'b0;
      o_nv_bp_write <= 1'b0;
      o_nv_bp_data <= 3'h0;
    end else begin
      o_program_start <= start_prog && !i_target_protected;
      o_erase_start <= start_erase && !i_target_protected;
      o_whole_erase_start <= start_whole;
      o_erase_suspend <= cmd && busy_q && rx_byte == `FVS_OP_ERASE_SUSPEND &&
                         (op_q == FVS_OP_ERASE || op_q == FVS_OP_WHOLE);
      o_program_suspend <= cmd && busy_q && rx_byte == `FVS_OP_PROGRAM_SUSPEND &&
                           op_q == FVS_OP_PROG;
      o_nv_bp_write <= reg_write && !i_protect_volatility_select;
      if (reg_write) begin
        o_nv_bp_data <= rx_byte[`FVS_BIT_BP_HI:`FVS_BIT_BP_LO];
      end
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      o_volatile_status_one <= 8'h00;
    end else begin
      o_volatile_status_one <= status;
    end
  end

  // ********************************
  // read-out shifter
  // ********************************
  // the status byte is captured when the opcode or previous byte ends,
  // so a long read sees a fresh copy every eight clocks
  always_ff @(posedge i_ref_clk) begin
    if (i_srst || cs_n_s) begin
      out_q <= 8'h00;
      miso_q <= 1'b0;
    end else if (byte_done && (first_done ? is_read(rx_byte) : is_read(opcode_q))) begin
      out_q <= status;
    end else if (fall) begin
      miso_q <= out_q[7];
      out_q <= {out_q[6:0], 1'b0};
    end
  end

  assign link.miso = miso_q;

endmodule

// [src/fvs_params.svh]
/*
 * constants of the flash volatile status block: opcodes, bit positions,
 * reset values and the host's own register map.
 * assumes it is included by bare name from the package and the design files.
 */
`ifndef FVS_PARAMS_SVH
`define FVS_PARAMS_SVH

// ********************************
// opcodes
// ********************************
`define FVS_OP_READ_STATUS_ONE 8'h05
`define FVS_OP_READ_STATUS_TWO 8'h07
`define FVS_OP_READ_ANY_REG 8'h65
`define FVS_OP_WRITE_ANY_REG 8'h71
`define FVS_OP_WRITE_REGS 8'h01
`define FVS_OP_WRITE_ENABLE 8'h06
`define FVS_OP_WRITE_DISABLE 8'h04
`define FVS_OP_CLEAR_STATUS_A 8'h30
`define FVS_OP_CLEAR_STATUS_B 8'h82
`define FVS_OP_PROGRAM 8'h02
`define FVS_OP_SECTOR_ERASE 8'hd8
`define FVS_OP_WHOLE_ERASE 8'h60
`define FVS_OP_ERASE_SUSPEND 8'h75
`define FVS_OP_PROGRAM_SUSPEND 8'h85
`define FVS_OP_SOFT_RESET 8'hf0

// ********************************
// status register bit positions
// ********************************
`define FVS_BIT_BUSY 0
`define FVS_BIT_WEL 1
`define FVS_BIT_BP_LO 2
`define FVS_BIT_BP_HI 4
`define FVS_BIT_E_ERR 5
`define FVS_BIT_P_ERR 6
`define FVS_BIT_STATUS_WRITE_DISABLE_MIRROR 7

// ********************************
// link framing
// ********************************
`define FVS_BYTE_LAST 3'h7
`define FVS_FIRST_BYTE_END 5'h07
`define FVS_SECOND_BYTE_END 5'h0f
`define FVS_BIT_CNT_RESET 5'h00

// ********************************
// host register map (apb byte addresses), control bit and link timing
// ********************************
`define FVS_HOST_CTRL_ADDR 8'h00
`define FVS_HOST_STATUS_ADDR 8'h04
`define FVS_CTRL_TWO_BYTE 16
`define FVS_HOST_HALF_PERIOD 8
`define FVS_HOST_GAP_HALVES 2

`endif

// [src/fvs_pkg.sv]
/*
 * types shared by both ends of the flash volatile status link.
 * assumes fvs_params.svh is on the include path.
 */
`include "fvs_params.svh"

package fvs_pkg;

  // ********************************
  // embedded operation in flight
  // ********************************
  typedef enum logic [1:0] {
    FVS_OP_NONE,
    FVS_OP_PROG,
    FVS_OP_ERASE,
    FVS_OP_WHOLE
  } fvs_op_e;

  // ********************************
  // host link sequencer
  // ********************************
  typedef enum logic [1:0] {
    FVS_HS_IDLE,
    FVS_HS_SHIFT,
    FVS_HS_GAP
  } fvs_host_state_e;

endpackage

// [src/fvs_link_if.sv]
/*
 * serial link between the flash host controller and the flash device.
 * assumes the host makes the serial clock; mode 0 framing.
 */
interface fvs_link_if;
  logic sclk;
  logic cs_n;
  logic mosi;
  logic miso;

  modport device (
    input sclk,
    input cs_n,
    input mosi,
    output miso
  );

  modport host (
    output sclk,
    output cs_n,
    output mosi,
    input miso
  );
endinterface

// [src/fvs_sync3.sv]
/*
 * three flop synchroniser for pins from outside the clock domain.
 * a change is passed on once the second and third stages agree.
 */
module fvs_sync3 #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  input wire logic i_ref_clk,
  input wire logic i_srst,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] s1_q;
  logic [WIDTH-1:0] s2_q;
  logic [WIDTH-1:0] s3_q;
  logic [WIDTH-1:0] out_q;

  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      s1_q <= INIT;
      s2_q <= INIT;
      s3_q <= INIT;
    end else begin
      s1_q <= i_async;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // per bit: take the new level only when both later stages agree
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      out_q <= INIT;
    end else begin
      out_q <= (s2_q & s3_q) | (out_q & (s2_q | s3_q));
    end
  end

  assign o_sync = out_q;
endmodule

// [src/fvs_host.sv]
/*
 * flash host controller end: an apb slave with a control and a status
 * register, and a sequencer that clocks one or two bytes over the link.
 * assumes a 32-bit apb master on i_ref_clk; the link clock is made here.
 */
`include "fvs_params.svh"

module fvs_host
  import fvs_pkg::*;
#(
  parameter int HALF_PERIOD = `FVS_HOST_HALF_PERIOD
) (
  input wire logic i_ref_clk,
  input wire logic i_srst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  fvs_link_if.host link
);

  // ********************************
  // apb slave
  // ********************************
  fvs_host_state_e state_q;
  logic [7:0] rx_q;
  logic access;
  logic mapped;
  logic start;

  assign mapped = i_paddr == `FVS_HOST_CTRL_ADDR || i_paddr == `FVS_HOST_STATUS_ADDR;
  assign access = i_psel && i_penable && o_pready;
  // a new command while a frame runs is dropped
  assign start = access && i_pwrite && i_paddr == `FVS_HOST_CTRL_ADDR &&
                 state_q == FVS_HS_IDLE;

  // answer in the first access cycle: zero wait states
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata <= 32'h0000_0000;
    end else begin
      o_pready <= i_psel && !i_penable;
      o_pslverr <= i_psel && !i_penable && !mapped;
      if (i_psel && !i_penable && !i_pwrite && i_paddr == `FVS_HOST_STATUS_ADDR) begin
        o_prdata <= {16'h0000, rx_q, 7'h00, state_q != FVS_HS_IDLE};
      end else begin
        o_prdata <= 32'h0000_0000;
      end
    end
  end

  // ********************************
  // link sequencer
  // ********************************
  logic miso_s;
  logic [15:0] tx_q;
  logic [4:0] bit_q;
  logic [4:0] last_bit_q;
  logic [7:0] div_q;
  logic [1:0] gap_q;
  logic sclk_q;
  logic cs_n_q;
  logic mosi_q;
  logic tick;

  fvs_sync3 #(.WIDTH(1), .INIT(1'b0)) u_sync (
    .i_ref_clk(i_ref_clk),
    .i_srst(i_srst),
    .i_async(link.miso),
    .o_sync(miso_s)
  );

  assign tick = div_q == 8'(HALF_PERIOD - 1);

  always_ff @(posedge i_ref_clk) begin
    if (i_srst || state_q == FVS_HS_IDLE || tick) begin
      div_q <= 8'h00;
    end else begin
      div_q <= div_q + 8'h01;
    end
  end

  // mode 0: data set while low, sampled by the device on the rise;
  // miso is taken just before each fall to cover both synchronisers
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      state_q <= FVS_HS_IDLE;
      sclk_q <= 1'b0;
      cs_n_q <= 1'b1;
      mosi_q <= 1'b0;
      tx_q <= 16'h0000;
      bit_q <= 5'h00;
      last_bit_q <= 5'h00;
      gap_q <= 2'h0;
      rx_q <= 8'h00;
    end else begin
      case (state_q)
        FVS_HS_IDLE: begin
          if (start) begin
            state_q <= FVS_HS_SHIFT;
            cs_n_q <= 1'b0;
            tx_q <= {i_pwdata[7:0], i_pwdata[15:8]};
            mosi_q <= i_pwdata[7];
            bit_q <= 5'h00;
            last_bit_q <= i_pwdata[`FVS_CTRL_TWO_BYTE] ? `FVS_SECOND_BYTE_END :
                                                         `FVS_FIRST_BYTE_END;
          end
        end
        FVS_HS_SHIFT: begin
          if (tick && !sclk_q) begin
            sclk_q <= 1'b1;
          end else if (tick) begin
            sclk_q <= 1'b0;
            rx_q <= {rx_q[6:0], miso_s};
            tx_q <= {tx_q[14:0], 1'b0};
            mosi_q <= tx_q[14];
            bit_q <= bit_q + 5'h01;
            if (bit_q == last_bit_q) begin
              state_q <= FVS_HS_GAP;
              cs_n_q <= 1'b1;
              gap_q <= 2'h0;
            end
          end
        end
        FVS_HS_GAP: begin
          if (tick) begin
            gap_q <= gap_q + 2'h1;
            if (gap_q == 2'(`FVS_HOST_GAP_HALVES - 1)) begin
              state_q <= FVS_HS_IDLE;
            end
          end
        end
        default: begin
          state_q <= FVS_HS_IDLE;
        end
      endcase
    end
  end

  assign link.sclk = sclk_q;
  assign link.cs_n = cs_n_q;
  assign link.mosi = mosi_q;

endmodule

// [dv/fvs_link_monitor.sv]
/*
 * checker for the flash status link: watches the link wires and the
 * device's user side.
 * assumes one clock domain and a synchronous active-high reset.
 */
module fvs_link_monitor (
  input wire logic i_ref_clk,
  input wire logic i_srst,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  input wire logic miso,
  input wire logic [7:0] i_nv_status,
  input wire logic i_protect_volatility_select,
  input wire logic i_op_done,
  input wire logic i_op_fail,
  input wire logic o_program_start,
  input wire logic o_erase_start,
  input wire logic o_whole_erase_start,
  input wire logic o_erase_suspend,
  input wire logic o_program_suspend,
  input wire logic o_nv_bp_write,
  input wire logic [7:0] o_volatile_status_one
);
  // ********************************
  // helpers
  // ********************************
  logic [7:0] s;
  logic start;
  assign s = o_volatile_status_one;
  assign start = o_program_start | o_erase_start | o_whole_erase_start;

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_srst);

  // ********************************
  // properties
  // ********************************
  status_write_disable_mirror_mirror_a: assert property (
    $changed(i_nv_status[7]) |-> ##[1:8] (s[7] == i_nv_status[7]))
    else $error("status bit 7 does not follow the write-disable bit");
  start_busy_a: assert property (start |-> ##[0:3] s[0])
    else $error("operation started without busy");
  start_wel_a: assert property (start |-> $past(s[1], 2))
    else $error("operation started with latch clear");
  start_idle_a: assert property (start |-> !$past(s[0], 2))
    else $error("operation started while busy");
  whole_bp_a: assert property (
    o_whole_erase_start |-> ($past(s[4:2], 2) == 3'h0))
    else $error("whole erase started with protect bits set");
  err_busy_a: assert property ((s[6] || s[5]) |-> s[0])
    else $error("error flag set without busy");
  done_wel_a: assert property (
    (i_op_done && !i_op_fail && s[0] && !s[6] && !s[5]) |-> ##[1:3] !s[1])
    else $error("latch not cleared after successful operation");
  suspend_busy_a: assert property (
    (o_erase_suspend || o_program_suspend) |-> $past(s[0], 2))
    else $error("suspend accepted while idle");
  nv_bp_a: assert property (
    o_nv_bp_write |-> !$past(i_protect_volatility_select))
    else $error("non-volatile protect write in volatile mode");
  frame_idle_a: assert property ($rose(cs_n) |-> !sclk)
    else $error("frame ended with link clock high");
endmodule

// [dv/flash_volatile_status_one_test.sv]
/*
 * self-checking bench: apb drives the host end, which talks to the device end.
 * assumes the host's zero-wait apb slave and a behavioural embedded engine.
 */
`include "fvs_params.svh"
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin err_total++; \
  $display("ERROR at %0t: got %h exp %h", $time, (a), (b)); end end

module flash_volatile_status_one_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk, srst, psel, penable, pwrite, pready, pslverr, slv;
  logic sel, prot, done, fail;
  logic [7:0] paddr, nv, exp_sr, d, sro;
  logic [31:0] pwdata, prdata, rd;
  logic [5:0] st;
  logic [2:0] nvd, nvd_seen;
  int err_total, num_checks, cnt[6], ecnt[6];

  fvs_link_if link();
  fvs_host #(.HALF_PERIOD(8)) u_fvs_host (.i_ref_clk(ref_clk), .i_srst(srst),
    .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
    .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .link(link.host));
  fvs_device u_fvs_device (.i_ref_clk(ref_clk), .i_srst(srst), .link(link.device),
    .i_nv_status(nv), .i_protect_volatility_select(sel), .i_target_protected(prot),
    .i_op_done(done), .i_op_fail(fail), .o_program_start(st[0]), .o_erase_start(st[1]),
    .o_whole_erase_start(st[2]), .o_erase_suspend(st[3]), .o_program_suspend(st[4]),
    .o_nv_bp_write(st[5]), .o_nv_bp_data(nvd), .o_volatile_status_one(sro));
  fvs_link_monitor u_fvs_link_monitor (.i_ref_clk(ref_clk), .i_srst(srst),
    .sclk(link.sclk), .cs_n(link.cs_n), .mosi(link.mosi), .miso(link.miso),
    .i_nv_status(nv), .i_protect_volatility_select(sel), .i_op_done(done),
    .i_op_fail(fail), .o_program_start(st[0]), .o_erase_start(st[1]),
    .o_whole_erase_start(st[2]), .o_erase_suspend(st[3]), .o_program_suspend(st[4]),
    .o_nv_bp_write(st[5]), .o_volatile_status_one(sro));

  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  // strobes are counted here so a missing or extra pulse shows in the totals
  always @(posedge ref_clk) begin
    foreach (st[i]) if (st[i] === 1'b1) cnt[i]++;
    if (st[5] === 1'b1) nvd_seen = nvd;
  end

  // ********************************
  // tasks
  // ********************************
  task automatic print_verdict;
    if (err_total == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      err_total++;
      print_verdict();
    end
    rd = prdata;
    slv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // one frame, then poll until the host sequencer is idle again
  task automatic cmd(input logic [7:0] op, input logic [7:0] dat, input logic two);
    apb(1'b1, `FVS_HOST_CTRL_ADDR, {15'h0000, two, dat, op});
    for (int i = 0; i < 200; i++) begin
      apb(1'b0, `FVS_HOST_STATUS_ADDR, 32'h0000_0000);
      if (rd[0] === 1'b0) return;
    end
    err_total++;
    print_verdict();
  endtask

  task automatic check_sr;
    cmd($urandom_range(1) ? `FVS_OP_READ_ANY_REG : `FVS_OP_READ_STATUS_ONE, 8'h00, 1'b1);
    `CHK(rd[15:8], exp_sr)
    foreach (cnt[i]) `CHK(cnt[i], ecnt[i])
  endtask

  task automatic opdone(input logic f);
    @(posedge ref_clk);
    done <= 1'b1;
    fail <= f;
    @(posedge ref_clk);
    done <= 1'b0;
    fail <= 1'b0;
    repeat (4) @(posedge ref_clk);
  endtask

  // ********************************
  // main sequence
  // ********************************
  initial begin
    srst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    rd = $urandom(12611);
    nv = {1'b1, 2'b00, 3'($urandom_range(7)), 2'b00};
    sel = 1'b1;
    prot = 1'b0;
    done = 1'b0;
    fail = 1'b0;
    exp_sr = nv;
    repeat (20) @(posedge ref_clk);
    srst <= 1'b0;
    check_sr();
    apb(1'b0, 8'h08, 32'h0000_0000);
    `CHK(slv, 1'b1)
    for (int i = 0; i < 4; i++) begin
      exp_sr[1] = 1'($urandom_range(1));
      cmd(exp_sr[1] ? `FVS_OP_WRITE_ENABLE : `FVS_OP_WRITE_DISABLE, 8'h00, 1'b0);
      check_sr();
    end
    for (int i = 0; i < 2; i++) begin
      d = 8'($urandom);
      cmd(`FVS_OP_WRITE_DISABLE, 8'h00, 1'b0);
      exp_sr[1] = 1'b0;
      cmd(i ? `FVS_OP_WRITE_ANY_REG : `FVS_OP_WRITE_REGS, d, 1'b1);
      check_sr();
      cmd(`FVS_OP_WRITE_ENABLE, 8'h00, 1'b0);
      cmd(i ? `FVS_OP_WRITE_ANY_REG : `FVS_OP_WRITE_REGS, d, 1'b1);
      exp_sr[4:2] = d[4:2];
      check_sr();
    end
    cmd(`FVS_OP_PROGRAM, 8'h00, 1'b0);
    check_sr();
    cmd(`FVS_OP_WRITE_ENABLE, 8'h00, 1'b0);
    cmd(`FVS_OP_PROGRAM, 8'h00, 1'b0);
    ecnt[0]++;
    exp_sr[1:0] = 2'b11;
    cmd(`FVS_OP_WRITE_DISABLE, 8'h00, 1'b0);
    cmd(`FVS_OP_ERASE_SUSPEND, 8'h00, 1'b0);
    cmd(`FVS_OP_PROGRAM_SUSPEND, 8'h00, 1'b0);
    ecnt[4]++;
    check_sr();
    opdone(1'b0);
    exp_sr[1:0] = 2'b00;
    check_sr();
    prot <= 1'b1;
    for (int k = 0; k < 2; k++) begin
      cmd(`FVS_OP_WRITE_ENABLE, 8'h00, 1'b0);
      cmd(k ? `FVS_OP_SECTOR_ERASE : `FVS_OP_PROGRAM, 8'h00, 1'b0);
      exp_sr[6 - k] = 1'b1;
      exp_sr[1:0] = 2'b11;
      check_sr();
      cmd(k ? `FVS_OP_CLEAR_STATUS_B : `FVS_OP_CLEAR_STATUS_A, 8'h00, 1'b0);
      exp_sr[6:5] = 2'b00;
      exp_sr[0] = 1'b0;
      check_sr();
      cmd(`FVS_OP_WRITE_DISABLE, 8'h00, 1'b0);
      exp_sr[1] = 1'b0;
    end
    prot <= 1'b0;
    cmd(`FVS_OP_WRITE_ENABLE, 8'h00, 1'b0);
    cmd(`FVS_OP_SECTOR_ERASE, 8'h00, 1'b0);
    cmd(`FVS_OP_PROGRAM_SUSPEND, 8'h00, 1'b0);
    cmd(`FVS_OP_ERASE_SUSPEND, 8'h00, 1'b0);
    ecnt[1]++;
    ecnt[3]++;
    opdone(1'b1);
    exp_sr[5] = 1'b1;
    exp_sr[1:0] = 2'b11;
    check_sr();
    cmd(`FVS_OP_CLEAR_STATUS_B, 8'h00, 1'b0);
    cmd(`FVS_OP_WRITE_DISABLE, 8'h00, 1'b0);
    exp_sr[5] = 1'b0;
    exp_sr[1:0] = 2'b00;
    cmd(`FVS_OP_WRITE_ENABLE, 8'h00, 1'b0);
    cmd(`FVS_OP_WRITE_REGS, 8'h1c, 1'b1);
    cmd(`FVS_OP_WRITE_ENABLE, 8'h00, 1'b0);
    cmd(`FVS_OP_WHOLE_ERASE, 8'h00, 1'b0);
    exp_sr[4:1] = 4'hf;
    check_sr();
    cmd(`FVS_OP_WRITE_REGS, 8'h00, 1'b1);
    cmd(`FVS_OP_WRITE_ENABLE, 8'h00, 1'b0);
    cmd(`FVS_OP_WHOLE_ERASE, 8'h00, 1'b0);
    ecnt[2]++;
    opdone(1'b1);
    exp_sr[4:0] = 5'h03;
    check_sr();
    cmd(`FVS_OP_CLEAR_STATUS_A, 8'h00, 1'b0);
    cmd(`FVS_OP_WRITE_DISABLE, 8'h00, 1'b0);
    d = 8'($urandom);
    sel <= 1'b0;
    nv <= {~nv[7], nv[6:5], d[7:5], nv[1:0]};
    repeat (8) @(posedge ref_clk);
    exp_sr = nv;
    cmd(`FVS_OP_WRITE_ENABLE, 8'h00, 1'b0);
    cmd(`FVS_OP_WRITE_REGS, d, 1'b1);
    ecnt[5]++;
    check_sr();
    `CHK(nvd_seen, d[4:2])
    cmd(`FVS_OP_WRITE_ENABLE, 8'h00, 1'b0);
    cmd(`FVS_OP_SOFT_RESET, 8'h00, 1'b0);
    check_sr();
    cmd(`FVS_OP_WRITE_ENABLE, 8'h00, 1'b0);
    srst <= 1'b1;
    repeat (4) @(posedge ref_clk);
    srst <= 1'b0;
    check_sr();
    print_verdict();
  end
endmodule
